// file: uitb_map.vh
// Register map, field positions and reset values of the IN endpoint transmit buffer
`ifndef UITB_MAP_VH
`define UITB_MAP_VH

`define UITB_OFF_DATA      12'h000
`define UITB_OFF_LEN       12'h004
`define UITB_OFF_CTRL      12'h008
`define UITB_OFF_STAT      12'h00C
`define UITB_OFF_FLAGS     12'h010

`define UITB_CTRL_EN       0
`define UITB_CTRL_FEN      1
`define UITB_CTRL_STL      3
`define UITB_CTRL_SOW      6
`define UITB_CTRL_CLR      7

`define UITB_STAT_ACK      0
`define UITB_STAT_ERR      1
`define UITB_STAT_NAK      2
`define UITB_STAT_STL      3
`define UITB_STAT_SEQ      7

`define UITB_FLG_OVR       0
`define UITB_FLG_UND       1
`define UITB_FLG_FULL      2
`define UITB_FLG_EMPTY     3

`define UITB_LEN_RST       4'h0
`define UITB_BYTE_RST      8'h00
`define UITB_WORD_ZERO     32'h0000_0000

`define UITB_HS_NONE       2'h0
`define UITB_HS_NAK        2'h1
`define UITB_HS_STALL      2'h2
`define UITB_HS_DATA       2'h3

`define UITB_PID_DATA0     4'h3
`define UITB_PID_DATA1     4'hB

`endif

// file: uitb_tx_buffer.v
// IN endpoint transmit FIFO, byte count and control logic with APB register access
//
// Contract
// - Each write to the data port pushes one 8-bit byte into the FIFO; here a write while full or during a clear is dropped.
// - A write to the length register sets the transmit-enable bit unless a clear or a host ACK clears it in the same cycle.
// - The length register holds its value during transmission; no countdown.
// - Setting fifo_clear resets pointers and flags, then the bit self-clears.
// - After a clear, empty flag is set and all other flags are cleared.
// - Toggle bit is writable only while sequence_overwrite is set; resets to zero.
// - With endpoint_stall set, the next valid IN gets a STALL.
// - With transmit enable set and endpoint_stall clear, the next valid IN gets the FIFO data packet.
// - Transmit enable clears when the acknowledge status bit becomes set.
// - Transmit enable also clears whenever fifo_clear is set.
// - Valid IN with transmission not enabled is answered with NACK.
// - Not enabled and stall set: answer STALL instead of NACK.
// - Control bit zero enables the endpoint; reset clears it.
// - Toggle bit flips after each good IN; selects DATA0 or DATA1 PID.
// - Host ACK sets acknowledge status and the transmit interrupt; software clears.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "uitb_map.vh"

module uitb_tx_buffer #(
  parameter DEPTH_LOG2 = 4,
  parameter ADDR_W     = 12
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rst_n,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // Serial engine: IN transaction request and handshake choice
  input  wire              in_token,
  output reg               in_resp_valid,
  output reg  [1:0]        in_resp_kind,
  output reg  [3:0]        in_data_pid,
  // Serial engine: byte stream of the data packet
  input  wire              tx_byte_ready,
  output reg               tx_byte_valid,
  output reg  [7:0]        tx_byte,
  output reg               tx_last,
  // Serial engine: end of an IN transaction
  input  wire              host_ack,
  input  wire              tx_error,
  input  wire              stall_sent,
  input  wire              nak_sent,
  // Status to the rest of the device
  output reg               tx_irq,
  output reg               endpoint_enable
);

  localparam DEPTH = 1 << DEPTH_LOG2;
  localparam [DEPTH_LOG2:0] DEPTH_FULL = DEPTH;

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  reg [7:0]            mem_q [0:DEPTH-1];
  reg [DEPTH_LOG2-1:0] wr_ptr_q;
  reg [DEPTH_LOG2-1:0] rd_ptr_q;
  reg [DEPTH_LOG2:0]   count_q;
  reg                  ovr_q;
  reg                  und_q;
  reg [3:0]            tx_packet_length_q;
  reg                  fifo_transmit_enable_q;
  reg                  endpoint_stall_q;
  reg                  sequence_overwrite_q;
  reg                  fifo_clear_q;
  reg                  data_toggle_sequence_q;
  reg                  ack_q;
  reg                  err_q;
  reg                  nak_q;
  reg                  stl_q;
  reg [1:0]            state_q;
  reg [3:0]            sent_q;

  wire       acc    = psel & penable;
  wire       wr     = acc & pwrite;
  wire       wr_dat = wr & (paddr == `UITB_OFF_DATA);
  wire       wr_len = wr & (paddr == `UITB_OFF_LEN);
  wire       wr_ctl = wr & (paddr == `UITB_OFF_CTRL);
  wire       wr_sta = wr & (paddr == `UITB_OFF_STAT);
  wire       mapped = (paddr == `UITB_OFF_DATA) | (paddr == `UITB_OFF_LEN) | (paddr == `UITB_OFF_CTRL) |
                      (paddr == `UITB_OFF_STAT) | (paddr == `UITB_OFF_FLAGS);
  wire       empty  = (count_q == {(DEPTH_LOG2+1){1'b0}});
  wire       full   = (count_q == DEPTH_FULL);
  wire       pop    = (state_q == ST_SEND) & tx_byte_valid & tx_byte_ready;
  wire       push   = wr_dat & ~full & ~fifo_clear_q;
  wire       do_pop = pop & ~empty;
  wire       go_in  = in_token & endpoint_enable & (state_q == ST_IDLE) & ~fifo_clear_q;
  wire       ack_ev = (state_q == ST_WAIT) & host_ack;
  wire       len0   = (tx_packet_length_q == `UITB_LEN_RST);

  // Writes through the data port, one byte each
  always @(posedge ref_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= pwdata[7:0];
  end

  // FIFO pointers and error flags; a clear takes one cycle and then releases itself
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= {DEPTH_LOG2{1'b0}};
      rd_ptr_q <= {DEPTH_LOG2{1'b0}};
      count_q  <= {(DEPTH_LOG2+1){1'b0}};
      ovr_q    <= 1'b0;
      und_q    <= 1'b0;
    end
    else if (fifo_clear_q)
    begin
      wr_ptr_q <= {DEPTH_LOG2{1'b0}};
      rd_ptr_q <= {DEPTH_LOG2{1'b0}};
      count_q  <= {(DEPTH_LOG2+1){1'b0}};
      ovr_q    <= 1'b0;
      und_q    <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push & ~do_pop)
        count_q <= count_q + 1'b1;
      else if (do_pop & ~push)
        count_q <= count_q - 1'b1;
      if (wr_dat & full)
        ovr_q <= 1'b1;
      if (pop & empty)
        und_q <= 1'b1;
    end
  end

  // Control and status registers
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_packet_length_q     <= `UITB_LEN_RST;
      fifo_transmit_enable_q <= 1'b0;
      endpoint_stall_q       <= 1'b0;
      sequence_overwrite_q   <= 1'b0;
      fifo_clear_q           <= 1'b0;
      endpoint_enable        <= 1'b0;
      data_toggle_sequence_q <= 1'b0;
      ack_q                  <= 1'b0;
      err_q                  <= 1'b0;
      nak_q                  <= 1'b0;
      stl_q                  <= 1'b0;
    end
    else
    begin
      if (wr_len)
        tx_packet_length_q <= pwdata[3:0];
      if (wr_ctl)
      begin
        endpoint_enable      <= pwdata[`UITB_CTRL_EN];
        endpoint_stall_q     <= pwdata[`UITB_CTRL_STL];
        sequence_overwrite_q <= pwdata[`UITB_CTRL_SOW];
        fifo_clear_q         <= pwdata[`UITB_CTRL_CLR];
      end
      else if (fifo_clear_q)
        fifo_clear_q <= 1'b0;
      // Hardware clears win over a simultaneous software set of the enable
      if ((wr_ctl & pwdata[`UITB_CTRL_CLR]) | fifo_clear_q | ack_ev)
        fifo_transmit_enable_q <= 1'b0;
      else if (wr_len)
        fifo_transmit_enable_q <= 1'b1;
      else if (wr_ctl)
        fifo_transmit_enable_q <= pwdata[`UITB_CTRL_FEN];
      if (ack_ev)
        data_toggle_sequence_q <= ~data_toggle_sequence_q;
      else if (wr_sta & sequence_overwrite_q)
        data_toggle_sequence_q <= pwdata[`UITB_STAT_SEQ];
      // Set wins over a software clear in the same cycle
      if (ack_ev)
        ack_q <= 1'b1;
      else if (wr_sta & ~pwdata[`UITB_STAT_ACK])
        ack_q <= 1'b0;
      if ((state_q == ST_WAIT) & (host_ack | tx_error | stall_sent | nak_sent))
      begin
        err_q <= tx_error;
        nak_q <= nak_sent;
        stl_q <= stall_sent;
      end
    end
  end

  // IN transaction sequencer
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q       <= ST_IDLE;
      sent_q        <= `UITB_LEN_RST;
      in_resp_valid <= 1'b0;
      in_resp_kind  <= `UITB_HS_NONE;
      in_data_pid   <= `UITB_PID_DATA0;
      tx_byte_valid <= 1'b0;
      tx_byte       <= `UITB_BYTE_RST;
      tx_last       <= 1'b0;
    end
    else
    begin
      in_resp_valid <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (go_in)
          begin
            in_resp_valid <= 1'b1;
            in_data_pid   <= data_toggle_sequence_q ? `UITB_PID_DATA1 : `UITB_PID_DATA0;
            sent_q        <= `UITB_LEN_RST;
            if (endpoint_stall_q)
            begin
              in_resp_kind <= `UITB_HS_STALL;
              state_q      <= ST_WAIT;
            end
            else if (fifo_transmit_enable_q)
            begin
              in_resp_kind  <= `UITB_HS_DATA;
              // A zero-length packet skips the byte phase and goes straight to CRC
              state_q       <= len0 ? ST_WAIT : ST_SEND;
              tx_byte_valid <= ~len0;
              tx_byte       <= mem_q[rd_ptr_q];
              tx_last       <= (tx_packet_length_q == 4'h1);
            end
            else
            begin
              in_resp_kind <= `UITB_HS_NAK;
              state_q      <= ST_WAIT;
            end
          end
        end
        ST_SEND:
        begin
          if (pop)
          begin
            sent_q <= sent_q + 1'b1;
            if (tx_last)
            begin
              tx_byte_valid <= 1'b0;
              tx_last       <= 1'b0;
              state_q       <= ST_WAIT;
            end
            else
            begin
              tx_byte <= mem_q[rd_ptr_q + 1'b1];
              tx_last <= ((sent_q + 4'h2) == tx_packet_length_q);
            end
          end
        end
        ST_WAIT:
        begin
          if (host_ack | tx_error | stall_sent | nak_sent)
          begin
            state_q      <= ST_IDLE;
            in_resp_kind <= `UITB_HS_NONE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (fifo_clear_q)
      begin
        state_q       <= ST_IDLE;
        tx_byte_valid <= 1'b0;
        tx_last       <= 1'b0;
      end
    end
  end

  // APB answers in the access cycle; reads are registered for the flop-output style
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= `UITB_WORD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      tx_irq  <= 1'b0;
    end
    else
    begin
      tx_irq  <= ack_q | ack_ev;
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~mapped;
      prdata  <= `UITB_WORD_ZERO;
      if (psel & ~penable & ~pwrite)
      begin
        if (paddr == `UITB_OFF_LEN)
          prdata[3:0] <= tx_packet_length_q;
        else if (paddr == `UITB_OFF_CTRL)
        begin
          prdata[`UITB_CTRL_EN]  <= endpoint_enable;
          prdata[`UITB_CTRL_FEN] <= fifo_transmit_enable_q;
          prdata[`UITB_CTRL_STL] <= endpoint_stall_q;
          prdata[`UITB_CTRL_SOW] <= sequence_overwrite_q;
          prdata[`UITB_CTRL_CLR] <= fifo_clear_q;
        end
        else if (paddr == `UITB_OFF_STAT)
        begin
          prdata[`UITB_STAT_ACK] <= ack_q;
          prdata[`UITB_STAT_ERR] <= err_q;
          prdata[`UITB_STAT_NAK] <= nak_q;
          prdata[`UITB_STAT_STL] <= stl_q;
          prdata[`UITB_STAT_SEQ] <= data_toggle_sequence_q;
        end
        else if (paddr == `UITB_OFF_FLAGS)
        begin
          prdata[`UITB_FLG_OVR]   <= ovr_q;
          prdata[`UITB_FLG_UND]   <= und_q;
          prdata[`UITB_FLG_FULL]  <= full;
          prdata[`UITB_FLG_EMPTY] <= empty;
        end
      end
    end
  end

endmodule // uitb_tx_buffer

`default_nettype wire

// file: uitb_tx_buffer_sva.sv
// Concurrent checks on the ports of the IN endpoint transmit buffer
`timescale 1ns/10ps
`default_nettype none
`include "uitb_map.vh"
module uitb_tx_buffer_sva #(
  parameter ADDR_W = 12
) (
  // Clock, reset and APB
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  // IN link
  input wire logic              in_token,
  input wire logic              in_resp_valid,
  input wire logic [1:0]        in_resp_kind,
  input wire logic [3:0]        in_data_pid,
  input wire logic              tx_byte_ready,
  input wire logic              tx_byte_valid,
  input wire logic              tx_last,
  input wire logic              host_ack,
  input wire logic              tx_error,
  input wire logic              stall_sent,
  input wire logic              nak_sent,
  // Status
  input wire logic              tx_irq,
  input wire logic              endpoint_enable
);
  logic       wr_done;
  logic       wr_ctrl;
  logic       stl_q;
  logic       busy_q;
  logic [3:0] len_q;
  logic [3:0] cnt_q;
  assign wr_done = psel && penable && pready && pwrite;
  assign wr_ctrl = wr_done && paddr == `UITB_OFF_CTRL;
  // Shadow of the stall bit, length and transaction state as software set them
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      stl_q  <= 1'b0;
      busy_q <= 1'b0;
      len_q  <= 4'h0;
      cnt_q  <= 4'h0;
    end
    else
    begin
      if (wr_ctrl)
        stl_q <= pwdata[`UITB_CTRL_STL];
      if (wr_done && paddr == `UITB_OFF_LEN)
        len_q <= pwdata[3:0];
      // The first byte can be taken in the very cycle of the answer
      if (in_resp_valid)
        cnt_q <= (tx_byte_valid && tx_byte_ready) ? 4'h1 : 4'h0;
      else if (tx_byte_valid && tx_byte_ready)
        cnt_q <= cnt_q + 4'h1;
      if (in_resp_valid)
        busy_q <= 1'b1;
      else if (host_ack || tx_error || stall_sent || nak_sent)
        busy_q <= 1'b0;
    end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("access cycle without pready");
  AST_ENABLE_BIT: assert property (wr_ctrl |=> endpoint_enable == $past(pwdata[0]))
    else $error("endpoint enable does not follow control bit 0");
  AST_ENABLE_HOLD: assert property (!wr_ctrl |=> $stable(endpoint_enable))
    else $error("endpoint enable moved without a control write");
  AST_TOKEN_ANSWER: assert property (in_token && endpoint_enable && !busy_q && !in_resp_valid |=> in_resp_valid)
    else $error("valid IN token not answered");
  AST_STALL_CHOICE: assert property (in_resp_valid |-> (in_resp_kind == `UITB_HS_STALL) == stl_q)
    else $error("stall answer does not match the stall bit");
  AST_PID_CODE: assert property (in_resp_valid && in_resp_kind == `UITB_HS_DATA |->
    in_data_pid == `UITB_PID_DATA0 || in_data_pid == `UITB_PID_DATA1)
    else $error("data PID is neither DATA0 nor DATA1");
  AST_ACK_IRQ: assert property (busy_q && host_ack && in_resp_kind == `UITB_HS_DATA |-> ##[1:2] tx_irq)
    else $error("host ACK did not raise the transmit interrupt");
  AST_BYTE_COUNT: assert property (tx_byte_valid && tx_byte_ready && tx_last |->
    (in_resp_valid ? 4'h0 : cnt_q) == len_q - 4'h1)
    else $error("last byte does not match the loaded length");
  AST_NO_STREAM: assert property (tx_byte_valid |-> in_resp_kind == `UITB_HS_DATA)
    else $error("bytes streamed without a data answer");
endmodule // uitb_tx_buffer_sva
bind uitb_tx_buffer uitb_tx_buffer_sva #(.ADDR_W(ADDR_W)) uitb_tx_buffer_sva_inst (.ref_clk, .rst_n, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata, .in_token, .in_resp_valid, .in_resp_kind, .in_data_pid,
  .tx_byte_ready, .tx_byte_valid, .tx_last, .host_ack, .tx_error, .stall_sent, .nak_sent, .tx_irq,
  .endpoint_enable);
`default_nettype wire

// file: uitb_engine_model.sv
// Serial engine stand-in: takes the byte stream with random stalls and ends each NAK, STALL or non-empty data transaction
`timescale 1ns/10ps
`default_nettype none
`include "uitb_map.vh"
module uitb_engine_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // From the buffer
  input  wire logic       in_resp_valid,
  input  wire logic [1:0] in_resp_kind,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  // To the buffer
  output logic            tx_byte_ready,
  output logic            host_ack,
  output logic            tx_error,
  output logic            stall_sent,
  output logic            nak_sent
);
  logic [7:0] got[$];
  // No bus error is injected, so the error path stays unexercised
  assign tx_error = 1'b0;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      tx_byte_ready <= 1'b0;
      host_ack      <= 1'b0;
      stall_sent    <= 1'b0;
      nak_sent      <= 1'b0;
    end
    else
    begin
      // Random stalls make the buffer hold a byte while tx_byte_ready is low
      tx_byte_ready <= 1'($urandom % 2);
      host_ack      <= tx_byte_valid && tx_byte_ready && tx_last;
      nak_sent      <= in_resp_valid && in_resp_kind == `UITB_HS_NAK;
      stall_sent    <= in_resp_valid && in_resp_kind == `UITB_HS_STALL;
      if (tx_byte_valid && tx_byte_ready)
        got.push_back(tx_byte);
    end
endmodule // uitb_engine_model
`default_nettype wire

// file: tb_uitb_tx_buffer.sv
// Self-checking bench of the IN endpoint transmit buffer against a reference model
`timescale 1ns/10ps
`default_nettype none
`include "uitb_map.vh"
module tb_uitb_tx_buffer;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        in_token = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] r;
  logic        e;
  logic [7:0]  q[$];
  wire  [31:0] prdata;
  wire  [1:0]  in_resp_kind;
  wire  [3:0]  in_data_pid;
  wire  [7:0]  tx_byte;
  wire         pready, pslverr, in_resp_valid, tx_byte_ready, tx_byte_valid, tx_last;
  wire         host_ack, tx_error, stall_sent, nak_sent, tx_irq, endpoint_enable;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  int          tog_m = 0;
  always #25 ref_clk = ~ref_clk;
  uitb_tx_buffer uitb_tx_buffer_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .in_token, .in_resp_valid, .in_resp_kind, .in_data_pid, .tx_byte_ready, .tx_byte_valid,
    .tx_byte, .tx_last, .host_ack, .tx_error, .stall_sent, .nak_sent, .tx_irq, .endpoint_enable);
  uitb_engine_model uitb_engine_model_inst (.ref_clk, .rst_n, .in_resp_valid, .in_resp_kind, .tx_byte_valid,
    .tx_byte, .tx_last, .tx_byte_ready, .host_ack, .tx_error, .stall_sent, .nak_sent);
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never sees pready
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task txn(input logic [1:0] k);
    uitb_engine_model_inst.got.delete();
    @(posedge ref_clk);
    in_token <= 1'b1;
    @(posedge ref_clk);
    in_token <= 1'b0;
    // Waits end only by the answer or by the bench's cycle ceiling
    while (in_resp_valid !== 1'b1)
      @(posedge ref_clk);
    chk(in_resp_kind, k);
    if (k == `UITB_HS_DATA)
      chk(in_data_pid, tog_m ? `UITB_PID_DATA1 : `UITB_PID_DATA0);
    while ((host_ack | nak_sent | stall_sent) !== 1'b1)
      @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  // The sequence needs about 400 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(32'hb0f4));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, `UITB_OFF_CTRL, 8'h00);
    chk(r, `UITB_WORD_ZERO);
    apb(1'b0, `UITB_OFF_LEN, 8'h00);
    chk(r, `UITB_WORD_ZERO);
    apb(1'b0, `UITB_OFF_STAT, 8'h00);
    chk(r, `UITB_WORD_ZERO);
    apb(1'b0, 12'h020, 8'h00);
    chk(e, 1'b1);
    apb(1'b1, `UITB_OFF_CTRL, 8'h01);
    txn(`UITB_HS_NAK);
    apb(1'b1, `UITB_OFF_CTRL, 8'h09);
    txn(`UITB_HS_STALL);
    apb(1'b1, `UITB_OFF_DATA, 8'h5a);
    apb(1'b1, `UITB_OFF_LEN, 8'h01);
    txn(`UITB_HS_STALL);
    apb(1'b1, `UITB_OFF_CTRL, 8'h81);
    apb(1'b0, `UITB_OFF_CTRL, 8'h00);
    chk(r, 32'h0000_0001);
    apb(1'b0, `UITB_OFF_FLAGS, 8'h00);
    chk(r, 32'h0000_0008);
    txn(`UITB_HS_NAK);
    apb(1'b1, `UITB_OFF_STAT, 8'h80);
    apb(1'b0, `UITB_OFF_STAT, 8'h00);
    // The NAK status of the last transaction stands; the toggle write is refused
    chk(r, 32'h0000_0004);
    apb(1'b1, `UITB_OFF_CTRL, 8'h41);
    apb(1'b1, `UITB_OFF_STAT, 8'h80);
    apb(1'b1, `UITB_OFF_CTRL, 8'h01);
    apb(1'b0, `UITB_OFF_STAT, 8'h00);
    chk(r, 32'h0000_0084);
    // Overfill the sixteen-byte FIFO by one byte, then recover by a clear
    repeat (17)
      apb(1'b1, `UITB_OFF_DATA, 8'($urandom));
    apb(1'b0, `UITB_OFF_FLAGS, 8'h00);
    chk(r, 32'h0000_0005);
    apb(1'b1, `UITB_OFF_CTRL, 8'h81);
    apb(1'b0, `UITB_OFF_FLAGS, 8'h00);
    chk(r, 32'h0000_0008);
    tog_m = 1;
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 3) ? 15 : 1 + $urandom % 8;
      q.delete();
      repeat (n)
      begin
        q.push_back(8'($urandom));
        apb(1'b1, `UITB_OFF_DATA, q[$]);
      end
      apb(1'b1, `UITB_OFF_LEN, 8'(n));
      apb(1'b0, `UITB_OFF_CTRL, 8'h00);
      chk(r, 32'h0000_0003);
      txn(`UITB_HS_DATA);
      chk(uitb_engine_model_inst.got.size(), n);
      foreach (q[i])
        chk(uitb_engine_model_inst.got[i], q[i]);
      tog_m ^= 1;
      apb(1'b0, `UITB_OFF_LEN, 8'h00);
      chk(r, n);
      apb(1'b0, `UITB_OFF_STAT, 8'h00);
      chk(r, {24'h00_0000, tog_m[0], 7'h01});
      chk(tx_irq, 1'b1);
      apb(1'b0, `UITB_OFF_CTRL, 8'h00);
      chk(r, 32'h0000_0001);
      apb(1'b1, `UITB_OFF_STAT, {tog_m[0], 7'h00});
      apb(1'b0, `UITB_OFF_STAT, 8'h00);
      chk(tx_irq, 1'b0);
    end
    finish_test();
  end
endmodule // tb_uitb_tx_buffer
`default_nettype wire
